// >>> common/ceib_pkg.sv
package ceib_pkg;

  // ************************************************************
  // register map (word aligned, byte offsets)
  // ************************************************************
  localparam logic [5:0] TX_IDENT_BYTE_0  = 6'h00;
  localparam logic [5:0] TX_IDENT_BYTE_1  = 6'h04;
  localparam logic [5:0] TX_IDENT_BYTE_2  = 6'h08;
  localparam logic [5:0] TX_IDENT_BYTE_3  = 6'h0C;
  localparam logic [5:0] RX_IDENT_BYTE_0  = 6'h10;
  localparam logic [5:0] RX_IDENT_BYTE_1  = 6'h14;
  localparam logic [5:0] RX_IDENT_BYTE_2  = 6'h18;
  localparam logic [5:0] RX_IDENT_BYTE_3  = 6'h1C;
  localparam logic [5:0] CTRL_STATUS      = 6'h20;

  // ************************************************************
  // control / status field positions
  // ************************************************************
  localparam int CTRL_TX_REQ_BIT   = 0;   // write 1: send tx identifier
  localparam int STAT_TX_EMPTY_BIT = 1;   // tx_buffer_empty_flag
  localparam int STAT_RX_FULL_BIT  = 2;   // rx_buffer_full_flag, write 1 clears
  localparam int CTRL_STATUS_RESET = 2;   // empty set, full clear

  // ************************************************************
  // identifier byte 1 and byte 3 field positions (extended and standard mapping)
  // ************************************************************
  localparam int EXT_SRR_BIT = 4;
  localparam int EXT_IDE_BIT = 3;
  localparam int EXT_RTR_BIT = 0;         // in byte 3
  localparam int STD_RTR_BIT = 4;         // in byte 1
  localparam int STD_IDE_BIT = 3;

  // ************************************************************
  // serial field lengths
  // ************************************************************
  localparam int EXT_FIELD_LEN = 32;      // id28..18, srr, ide, id17..0, rtr
  localparam int STD_FIELD_LEN = 13;      // id10..0, rtr, ide
  localparam int BIT_TIME_CYC  = 4;       // bit enable divider

  // ************************************************************
  // transmitter states
  // ************************************************************
  typedef enum logic [2:0] {
    CEIB_IDLE = 3'b001,
    CEIB_LOAD = 3'b010,
    CEIB_SEND = 3'b100
  } ceib_state_t;

endpackage : ceib_pkg

// >>> rtl/ceib_deserializer.sv
`timescale 1ns/1ps

module ceib_deserializer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // stream input
  input  wire logic        sof_i,
  input  wire logic        bit_i,
  input  wire logic        valid_i,
  // collected field
  output logic [31:0]      field_o,
  output logic [5:0]       count_o
);

  // shift in received bits, msb first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      field_o <= 32'h0000_0000;
      count_o <= 6'h00;
    end else if (sof_i) begin
      field_o <= 32'h0000_0000;
      count_o <= 6'h00;
    end else if (valid_i && count_o != 6'h20) begin
      field_o <= {field_o[30:0], bit_i};
      count_o <= count_o + 6'h01;
    end
  end

endmodule : ceib_deserializer

// >>> rtl/ceib_ident_buffer.sv
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps

// What this block does
// (R1) Extended identifier held as 29 bits, ID28..0, over four identifier bytes.
// (R2) Identifier bit 28 goes onto the bus first.
// (R3) Numerically lower identifier means higher priority.
// (R4) Byte 0 holds ID28..21 in bits 7..0.
// (R5) Byte 1 holds ID20..18, SRR, IDE, ID17..15.
// (R6) Byte 2 holds ID14..7 in bits 7..0.
// (R7) Byte 3 holds ID6..0 in bits 7..1 and RTR in bit 0.
// (R8) RTR location depends on the format in use.
// (R9) Extended frames carry SRR and IDE both one; SRR sent recessive.
// (R10) Software writes SRR as one before requesting extended transmission.
// (R11) Received SRR is stored exactly as seen on the bus.
// (R12) IDE zero selects 11-bit, one selects 29-bit identifier.
// (R13) Receive IDE shows the received frame format.
// (R14) Transmit IDE chooses standard or extended identifier to send.
// (R15) Receive RTR captures received frame type: 0 data, 1 remote.
// (R16) Transmit RTR is sent as programmed.
// (R17) Buffer contents are undefined after reset.
// (R18) Software touches buffers only when empty or full flags allow.
// (R19) Order sent: ID28..18, SRR, IDE, ID17..0, RTR.
module ceib_ident_buffer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // transmit bit stream
  output logic             tx_bit_o,
  output logic             tx_valid_o,
  output logic             tx_busy_o,
  output logic             tx_ide_o,
  // receive bit stream
  input  wire logic        rx_sof_i,
  input  wire logic        rx_bit_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_eof_i,
  // priority compare
  input  wire logic [28:0] cmp_id_i,
  output logic             tx_wins_o
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0]  tx_ident [0:3];               // R17
  logic [7:0]  rx_ident [0:3];               // R17
  logic        tx_buffer_empty_flag;
  logic        rx_buffer_full_flag;
  ceib_pkg::ceib_state_t state;
  ceib_pkg::ceib_state_t next_state;
  logic [1:0]  div_cnt;
  logic        bit_en;
  logic        ser_start;
  logic        ser_busy;
  logic [31:0] ser_field;
  logic [5:0]  ser_len;
  logic [31:0] rx_field;
  logic [5:0]  rx_count;
  logic        acc;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic        mapped;
  logic        rx_clr;

  // ************************************************************
  // field helpers
  // ************************************************************
  // extended id from four bytes
  function automatic logic [28:0] ext_id(input logic [7:0] b0, input logic [7:0] b1,
                                         input logic [7:0] b2, input logic [7:0] b3);
    ext_id = {b0, b1[7:5], b1[2:0], b2, b3[7:1]};         // R1 R4 R5 R6 R7
  endfunction : ext_id

  // rtr bit selected by format
  function automatic logic rtr_of(input logic [7:0] b1, input logic [7:0] b3);
    rtr_of = b1[ceib_pkg::EXT_IDE_BIT] ? b3[ceib_pkg::EXT_RTR_BIT]
                                       : b1[ceib_pkg::STD_RTR_BIT];   // R8
  endfunction : rtr_of

  // ************************************************************
  // wishbone decode
  // ************************************************************
  assign acc    = cyc_i && stb_i && !ack_o && !err_o;
  assign mapped = (adr_i[5:2] <= ceib_pkg::CTRL_STATUS[5:2]) && (adr_i[1:0] == 2'b00);

  // tx bytes writable only while empty; rx bytes not writable
  assign wr_ok  = acc && we_i && sel_i[0] && tx_buffer_empty_flag;   // R18

  // ack or error one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= acc && mapped;
      err_o <= acc && !mapped;
    end
  end

  // read mux, unused upper bits zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      ceib_pkg::TX_IDENT_BYTE_0: rd_data[7:0] = tx_ident[0];
      ceib_pkg::TX_IDENT_BYTE_1: rd_data[7:0] = tx_ident[1];
      ceib_pkg::TX_IDENT_BYTE_2: rd_data[7:0] = tx_ident[2];
      ceib_pkg::TX_IDENT_BYTE_3: rd_data[7:0] = tx_ident[3];
      ceib_pkg::RX_IDENT_BYTE_0: rd_data[7:0] = rx_ident[0];
      ceib_pkg::RX_IDENT_BYTE_1: rd_data[7:0] = rx_ident[1];
      ceib_pkg::RX_IDENT_BYTE_2: rd_data[7:0] = rx_ident[2];
      ceib_pkg::RX_IDENT_BYTE_3: rd_data[7:0] = rx_ident[3];
      ceib_pkg::CTRL_STATUS: begin
        rd_data[ceib_pkg::STAT_TX_EMPTY_BIT] = tx_buffer_empty_flag;
        rd_data[ceib_pkg::STAT_RX_FULL_BIT]  = rx_buffer_full_flag;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0000_0000;
    else if (acc) dat_o <= rd_data;
  end

  // ************************************************************
  // transmit buffer writes
  // ************************************************************
  // no reset: ram-like contents
  always_ff @(posedge clk_i) begin
    if (wr_ok && adr_i[5:4] == 2'b00) begin
      tx_ident[adr_i[3:2]] <= dat_i[7:0];
    end
  end

  // ************************************************************
  // flags
  // ************************************************************
  // tx empty: cleared by request, set when frame finishes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buffer_empty_flag <= ceib_pkg::CTRL_STATUS_RESET[ceib_pkg::STAT_TX_EMPTY_BIT];
    end else if (state == ceib_pkg::CEIB_SEND && !ser_busy) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (wr_ok && adr_i == ceib_pkg::CTRL_STATUS && dat_i[ceib_pkg::CTRL_TX_REQ_BIT]) begin
      tx_buffer_empty_flag <= 1'b0;
    end
  end

  // software clear of rx full flag
  assign rx_clr = acc && we_i && sel_i[0] && adr_i == ceib_pkg::CTRL_STATUS
                  && dat_i[ceib_pkg::STAT_RX_FULL_BIT];

  // rx full: set at end of frame wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buffer_full_flag <= 1'b0;
    end else if (rx_eof_i) begin
      rx_buffer_full_flag <= 1'b1;
    end else if (rx_clr) begin
      rx_buffer_full_flag <= 1'b0;
    end
  end

  // ************************************************************
  // transmit sequencing
  // ************************************************************
  // bit rate enable
  always_ff @(posedge clk_i) begin
    if (rst_i) div_cnt <= 2'h0;
    else div_cnt <= div_cnt + 2'h1;
  end
  assign bit_en = (div_cnt == 2'(ceib_pkg::BIT_TIME_CYC - 1));

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ceib_pkg::CEIB_IDLE: if (!tx_buffer_empty_flag) next_state = ceib_pkg::CEIB_LOAD;
      ceib_pkg::CEIB_LOAD: next_state = ceib_pkg::CEIB_SEND;
      ceib_pkg::CEIB_SEND: if (!ser_busy) next_state = ceib_pkg::CEIB_IDLE;
      default: next_state = ceib_pkg::CEIB_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) state <= ceib_pkg::CEIB_IDLE;
    else state <= next_state;
  end

  assign ser_start = (state == ceib_pkg::CEIB_IDLE) && !tx_buffer_empty_flag;

  // build left-justified field by format
  always_comb begin
    ser_field = 32'h0000_0000;
    ser_len   = 6'(ceib_pkg::STD_FIELD_LEN);
    if (tx_ident[1][ceib_pkg::EXT_IDE_BIT]) begin                    // R12 R14
      ser_field = {tx_ident[0], tx_ident[1][7:5],                    // R19
                   1'b1,                                             // R9
                   1'b1,                                             // R9
                   tx_ident[1][2:0], tx_ident[2], tx_ident[3][7:1],
                   tx_ident[3][ceib_pkg::EXT_RTR_BIT]};              // R16
      ser_len   = 6'(ceib_pkg::EXT_FIELD_LEN);
    end else begin
      ser_field = {tx_ident[0], tx_ident[1][7:5],
                   rtr_of(tx_ident[1], tx_ident[3]), 1'b0, 19'h00000};  // R8 R16
    end
  end

  // id28 leaves first, msb of the field
  ceib_serializer u_ser (                                            // R2
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (ser_start),
    .bit_en_i (bit_en),
    .field_i  (ser_field),
    .len_i    (ser_len),
    .bit_o    (tx_bit_o),
    .valid_o  (tx_valid_o),
    .busy_o   (ser_busy)
  );

  assign tx_busy_o = ser_busy || (state != ceib_pkg::CEIB_IDLE);
  assign tx_ide_o  = tx_ident[1][ceib_pkg::EXT_IDE_BIT];             // R14

  // lower id wins arbitration
  assign tx_wins_o = ext_id(tx_ident[0], tx_ident[1], tx_ident[2], tx_ident[3]) < cmp_id_i;  // R3

  // ************************************************************
  // receive capture
  // ************************************************************
  ceib_deserializer u_des (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sof_i   (rx_sof_i),
    .bit_i   (rx_bit_i),
    .valid_i (rx_valid_i),
    .field_o (rx_field),
    .count_o (rx_count)
  );

  // store received identifier at frame end; a clear in the same cycle frees the buffer
  always_ff @(posedge clk_i) begin
    if (rx_eof_i && (!rx_buffer_full_flag || rx_clr)) begin
      if (rx_count == 6'(ceib_pkg::EXT_FIELD_LEN)) begin
        rx_ident[0] <= rx_field[31:24];                              // R4
        rx_ident[1] <= {rx_field[23:21], rx_field[20],               // R11
                        rx_field[19], rx_field[18:16]};              // R5 R13
        rx_ident[2] <= rx_field[15:8];                               // R6
        rx_ident[3] <= rx_field[7:0];                                // R7 R15
      end else begin
        rx_ident[0] <= rx_field[12:5];
        rx_ident[1] <= {rx_field[4:2], rx_field[1], rx_field[0], 3'h0};  // R8 R13 R15
      end
    end
  end

endmodule : ceib_ident_buffer

// >>> rtl/ceib_serializer.sv
`timescale 1ns/1ps

module ceib_serializer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // stream control
  input  wire logic        start_i,
  input  wire logic        bit_en_i,
  input  wire logic [31:0] field_i,
  input  wire logic [5:0]  len_i,
  // stream output
  output logic             bit_o,
  output logic             valid_o,
  output logic             busy_o
);

  logic [31:0] shreg;
  logic [5:0]  left;

  // msb first shifting of a left-justified field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg   <= 32'h0000_0000;
      left    <= 6'h00;
      bit_o   <= 1'b1;
      valid_o <= 1'b0;
    end else if (start_i) begin
      shreg   <= field_i;
      left    <= len_i;
      valid_o <= 1'b0;
    end else if (bit_en_i && left != 6'h00) begin
      bit_o   <= shreg[31];                                  // R2
      shreg   <= {shreg[30:0], 1'b0};
      left    <= left - 6'h01;
      valid_o <= 1'b1;
    end else begin
      valid_o <= 1'b0;
      if (left == 6'h00 && bit_en_i) bit_o <= 1'b1;          // recessive idle
    end
  end

  assign busy_o = (left != 6'h00);

endmodule : ceib_serializer

// >>> testbench/ceib_can_peer.sv
`timescale 1ns/1ps

// ************************************************************
// bus side peer: collects sent bits, sends frames
// ************************************************************
module ceib_can_peer (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // from transmitter
  input  wire logic tx_bit_i,
  input  wire logic tx_valid_i,
  input  wire logic tx_busy_i,
  // to receiver
  output logic      rx_sof_o,
  output logic      rx_bit_o,
  output logic      rx_valid_o,
  output logic      rx_eof_o
);
  logic [31:0] cap;
  logic [5:0]  cnt;
  logic        busy_q;

  initial begin
    rx_sof_o = 1'b0;
    rx_bit_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_eof_o = 1'b0;
  end

  // previous busy level, marks frame start
  always @(posedge clk_i) busy_q <= tx_busy_i;

  // shift in each sent bit, first bit ends up highest
  always @(posedge clk_i) begin
    if (rst_i || (tx_busy_i && !busy_q && !tx_valid_i))
      cnt <= 6'h00;
    else if (tx_valid_i) begin
      cap <= {cap[30:0], tx_bit_i};
      cnt <= cnt + 6'h01;
    end
  end

  // frame out msb first, line toggles off the valid cycles
  task automatic send(input logic [31:0] f, input int n, input int gap);
    @(posedge clk_i);
    rx_sof_o <= 1'b1;
    @(posedge clk_i);
    rx_sof_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      rx_valid_o <= 1'b1;
      rx_bit_o <= f[i];
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_bit_o <= ~f[i];
      repeat (gap) @(posedge clk_i);
    end
    rx_eof_o <= 1'b1;
    @(posedge clk_i);
    rx_eof_o <= 1'b0;
  endtask : send
endmodule : ceib_can_peer

// >>> testbench/ceib_ident_props.sv
`timescale 1ns/1ps

// ************************************************************
// identifier buffer port checks
// ************************************************************
module ceib_ident_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus side
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // stream side
  input wire logic        tx_bit_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_busy_o,
  input wire logic        tx_ide_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [5:0] cnt;
  logic [5:0] len;

  // bits sent so far in the current frame
  always_ff @(posedge clk_i) begin
    if (rst_i || (!tx_busy_o && !tx_valid_o))
      cnt <= 6'h00;
    else if (tx_valid_o)
      cnt <= cnt + 6'h01;
  end
  assign len = tx_ide_o ? 6'h20 : 6'h0D;

  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  chk_resp_excl: assert property (!(ack_o && err_o)) else $error("ack and err together");
  chk_err_pulse: assert property (err_o |=> !err_o) else $error("err held too long");
  chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000) else $error("read data upper bits");
  chk_bit_space: assert property (tx_valid_o |=> !tx_valid_o [*3]) else $error("bit spacing short");
  chk_bit_hold: assert property (tx_busy_o && !tx_valid_o && cnt != 6'h00 && cnt < len |-> $stable(tx_bit_o))
    else $error("bit moved between enables");
  chk_srr_ide_one: assert property (tx_valid_o && tx_ide_o && (cnt == 6'h0B || cnt == 6'h0C) |-> tx_bit_o)
    else $error("srr or ide not recessive");
  chk_frame_len: assert property (tx_valid_o |-> cnt < len) else $error("frame too long");

  cov_ext_frame: cover property (tx_valid_o && tx_ide_o && cnt == 6'h1F);
  cov_std_frame: cover property (tx_valid_o && !tx_ide_o && cnt == 6'h0C);
  cov_err: cover property (err_o);
endmodule : ceib_ident_props

bind ceib_ident_buffer ceib_ident_props i_ceib_ident_props (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
  .err_o, .tx_bit_o, .tx_valid_o, .tx_busy_o, .tx_ide_o);

// >>> testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, er, r;
  logic        tx_bit_o, tx_valid_o, tx_busy_o, tx_ide_o, tx_wins_o;
  logic        rx_sof_i, rx_bit_i, rx_valid_i, rx_eof_i;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd, b, lfsr;
  logic [28:0] id, cmp_id_i;
  logic [10:0] sid;
  logic [31:0] exp_q[$];
  int          num_errors, tests_run, cycles;

  ceib_ident_buffer i_ceib_ident_buffer (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .err_o, .tx_bit_o, .tx_valid_o, .tx_busy_o, .tx_ide_o, .rx_sof_i, .rx_bit_i,
    .rx_valid_i, .rx_eof_i, .cmp_id_i, .tx_wins_o);
  ceib_can_peer i_ceib_can_peer (.clk_i, .rst_i, .tx_bit_i(tx_bit_o), .tx_valid_i(tx_valid_o),
    .tx_busy_i(tx_busy_o), .rx_sof_o(rx_sof_i), .rx_bit_o(rx_bit_i), .rx_valid_o(rx_valid_i),
    .rx_eof_o(rx_eof_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // four identifier bytes of the extended layout, byte 0 highest
  function automatic logic [31:0] ext_bytes(logic [28:0] i, logic s, logic t);
    return {i[28:21], i[20:18], s, 1'b1, i[17:15], i[14:7], i[6:0], t};
  endfunction : ext_bytes

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one classic cycle, held until ack or err
  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic wr_id(input logic [5:0] base, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      wb(base + 6'(4 * i), 1'b1, v[31 - 8 * i -: 8]);
  endtask : wr_id

  task automatic id_chk(input logic [5:0] base, input logic [31:0] v, input logic [31:0] m);
    for (int i = 0; i < 4; i++) begin
      wb(base + 6'(4 * i), 1'b0, 8'h00);
      chk({24'h0, rd[7:0] & m[31 - 8 * i -: 8]}, {24'h0, v[31 - 8 * i -: 8] & m[31 - 8 * i -: 8]});
    end
  endtask : id_chk

  task automatic send_wait(input logic [5:0] mask);
    wb(ceib_pkg::CTRL_STATUS, 1'b1, 8'h01);
    wb(ceib_pkg::TX_IDENT_BYTE_0, 1'b1, ~b[31:24]);
    do wb(ceib_pkg::CTRL_STATUS, 1'b0, 8'h00); while (rd[ceib_pkg::STAT_TX_EMPTY_BIT] !== 1'b1);
    wb(ceib_pkg::TX_IDENT_BYTE_0, 1'b0, 8'h00);
    chk({24'h0, rd[7:0]}, {24'h0, b[31:24]});
  endtask : send_wait

  task automatic test_done();
    $display("errors=%0d compares=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, cmp_id_i} = {1'b1, 45'h0, 29'h0};
    sel_i = 4'h1;
    lfsr = 32'h30;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(ceib_pkg::CTRL_STATUS, 1'b0, 8'h00);
    chk(rd & 32'h6, 32'h2);
    wb(6'h24, 1'b0, 8'h00);
    chk({31'h0, er}, 32'h1);
    $display("reset and map test done");
    for (int k = 0; k < 2; k++) begin
      b = rnd();
      id = b[28:0];
      r = k[0];
      cmp_id_i <= id ^ 29'h1;
      b = ext_bytes(id, 1'b1, r);
      wr_id(ceib_pkg::TX_IDENT_BYTE_0, b);
      id_chk(ceib_pkg::TX_IDENT_BYTE_0, b, 32'hFFFFFFFF);
      chk({30'h0, tx_wins_o, tx_ide_o}, {30'h0, ~id[0], 1'b1});
      exp_q.push_back({id[28:18], 2'b11, id[17:0], r});
      send_wait(6'h20);
      chk(i_ceib_can_peer.cap, exp_q.pop_front());
      chk({26'h0, i_ceib_can_peer.cnt}, 32'h20);
    end
    $display("extended transmit test done");
    b = rnd();
    sid = b[10:0];
    b = {sid, ~r, 1'b0, 3'h0, 16'h0};
    wr_id(ceib_pkg::TX_IDENT_BYTE_0, b);
    chk({31'h0, tx_ide_o}, 32'h0);
    send_wait(6'h0D);
    chk(i_ceib_can_peer.cap & 32'h1FFF, {19'h0, sid, ~r, 1'b0});
    chk({26'h0, i_ceib_can_peer.cnt}, 32'h0D);
    $display("standard transmit test done");
    for (int k = 0; k < 2; k++) begin
      b = rnd();
      id = b[28:0];
      i_ceib_can_peer.send({id[28:18], k[0], 1'b1, id[17:0], ~k[0]}, 32, 1 + 2 * k);
      wb(ceib_pkg::CTRL_STATUS, 1'b0, 8'h00);
      chk(rd & 32'h4, 32'h4);
      id_chk(ceib_pkg::RX_IDENT_BYTE_0, ext_bytes(id, k[0], ~k[0]), 32'hFFFFFFFF);
      wb(ceib_pkg::CTRL_STATUS, 1'b1, 8'h04);
    end
    i_ceib_can_peer.send({19'h0, sid, 1'b1, 1'b0}, 13, 1);
    id_chk(ceib_pkg::RX_IDENT_BYTE_0, {sid, 1'b1, 1'b0, 19'h0}, 32'hFFF80000);
    $display("receive test done");
    test_done();
  end
endmodule : tb_top
